// *** common/fmt_regs.svh ***
// Purpose: Constants of the stream formatter: characters, codes, sizes
// Assumes: ASCII output characters
// Notes: Definitions only
`ifndef FMT_REGS_SVH
`define FMT_REGS_SVH

// ----------------------------------------
// Characters
// ----------------------------------------
`define CHAR_CR 8'h0d
`define CHAR_LF 8'h0a
`define CHAR_MINUS 8'h2d
`define CHAR_SPACE 8'h20
`define CHAR_ZERO 8'h30
`define CHAR_POINT 8'h2e

// ----------------------------------------
// Division and decimal codes and sizes
// ----------------------------------------
`define DIV_CODE_UNUSED 2'h0
`define DIV_CODE_1 2'h1
`define DIV_CODE_2 2'h2
`define DIV_CODE_5 2'h3
`define DEC_CODE_TWO_ZEROS 3'h0
`define DEC_CODE_ONE_ZERO 3'h1
`define DEC_CODE_INTEGER 3'h2
`define DEC_CODE_FRAC_BASE 3'h2
`define STATUS_FIELD_ID_W 4
`define WEIGHT_W 24
`define MAX_DIGITS 8
`define BYTE_W 8
`define FIFO_DEPTH 16

`endif

// *** common/fmt_pkg.sv ***
// Purpose: Types shared by the stream formatter files
// Assumes: Constants come from fmt_regs.svh
// Notes: Field ids are four bits wide in a status token
package fmt_pkg;

    // ----------------------------------------
    // Token kinds and field options
    // ----------------------------------------
    typedef enum logic [2:0] {
        kind_hex, kind_cr, kind_lf, kind_status, kind_weight
    } token_kind_t;

    typedef enum logic [1:0] {
        sel_current, sel_gross, sel_net, sel_tare
    } weight_sel_t;

    typedef enum logic [1:0] {
        units_shown, units_primary, units_secondary, units_tertiary
    } units_t;

    typedef enum logic [3:0] {
        parity_field, constant_zero_field, constant_one_field,
        current_division_field, current_decimal_field,
        tertiary_decimal_field, unit_flag_field, motion_flag_field,
        range_flag_field, polarity_flag_field, gross_net_flag_field,
        no_field
    } field_id_t;

    typedef enum logic [2:0] {
        ph_idle, ph_load, ph_convert, ph_emit, ph_single
    } phase_t;

    // ----------------------------------------
    // Formatter state
    // ----------------------------------------
    typedef struct packed {
        phase_t phase;
        logic [7:0] byte_val;
        weight_sel_t sel;
        units_t units;
        logic right;
        logic sign_on;
        logic zero_on;
        logic fixed;
        logic dot_always;
        logic [2:0] fixed_digits;
        logic [3:0] width;
        logic [23:0] mag;
        logic neg;
        logic [31:0] digs;
        logic [3:0] ndig;
        logic [2:0] frac;
        logic [1:0] tz;
        logic [4:0] idx;
    } fmt_state_t;

endpackage

// *** rtl/byte_fifo.sv ***
// Purpose: Small FIFO between the formatter and the serial sender
// Assumes: Both sides on core_clk
// Notes: Ready and valid drop while ce is low, so nothing moves
`timescale 1ns/1ps
`include "fmt_regs.svh"

module byte_fifo #(
    parameter int WIDTH = `BYTE_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic full;
    logic empty;

    // ----------------------------------------
    // Flags and ports
    // ----------------------------------------
    assign empty = (st.wr == st.rd);
    assign full = (st.wr[AW] != st.rd[AW])
        && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign in_ready = ce && !full;
    assign out_valid = ce && !empty;
    assign out_data = st.mem[st.rd[AW-1:0]];

    always_comb begin
        next_st = st;
        if (in_valid && in_ready) begin
            next_st.mem[st.wr[AW-1:0]] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule

// *** rtl/weigh_stream_formatter.sv ***
// Purpose: Build ASCII stream frames from template tokens
// Assumes: Tokens, weights and flags come from logic on core_clk
// Notes: One byte per cycle into a 16 word FIFO; sender drains it
// Operation
// - Tertiary decimal code: 000..111 positions
// - Selector picks current, gross, net, tare
// - Upper case right, lower case left justified
// - Units suffix forces primary, secondary, tertiary
// - Sign option emits minus for negatives
// - Zero option pads with leading zeros
// - First digit sets field width
// - Point alone floats; point digit fixes
// - Double point sends trailing point too
// - Hex token emits that single byte
// - Status ids packed from bit 7 down
// - First status: parity,0,1,division,decimal
// - Second status: parity,0,1,five flags
// - Third status: parity,0,1, then zeros
// - Division code 01,10,11 for 1,2,5
// - Current decimal field uses same encoding
`timescale 1ns/1ps
`include "fmt_regs.svh"

module weigh_stream_formatter
    import fmt_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    // Template token
    input wire logic tok_valid,
    output logic tok_ready,
    input wire token_kind_t tok_kind,
    input wire logic [7:0] tok_byte,
    input wire logic [31:0] tok_fields,
    input wire weight_sel_t tok_select,
    input wire logic tok_right,
    input wire units_t tok_units,
    input wire logic tok_sign,
    input wire logic tok_zero,
    input wire logic [3:0] tok_width,
    input wire logic tok_fixed,
    input wire logic [2:0] tok_fixed_digits,
    input wire logic tok_dot_always,
    // Weight lookup
    output logic [1:0] weight_select,
    output logic [1:0] weight_units,
    input wire logic [23:0] weight_value,
    // Configuration
    input wire logic [2:0] display_division,
    input wire logic [2:0] current_decimal_field,
    input wire logic [2:0] primary_decimal_field,
    input wire logic [2:0] secondary_decimal_field,
    input wire logic [2:0] tertiary_decimal_field,
    // Scale flags
    input wire logic unit_flag,
    input wire logic motion_flag,
    input wire logic range_flag,
    input wire logic polarity_flag,
    input wire logic gross_net_flag,
    // Serial byte stream
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic busy
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] div_code(input logic [2:0] div);
        case (div)
            3'h1: div_code = `DIV_CODE_1;
            3'h2: div_code = `DIV_CODE_2;
            3'h5: div_code = `DIV_CODE_5;
            default: div_code = `DIV_CODE_UNUSED;
        endcase
    endfunction

    function automatic logic [7:0] pack_status(
        input logic [31:0] ids,
        input logic [1:0] div,
        input logic [2:0] dec, tdec,
        input logic [4:0] flags
    );
        int pos, w;
        logic [7:0] b, pmask;
        logic [2:0] v;
        field_id_t id;
        pos = 7;
        b = 8'h00;
        pmask = 8'h00;
        // Ids arrive most significant first; each fills its width
        for (int i = 0; i < 8; i++) begin
            id = field_id_t'(ids[31-`STATUS_FIELD_ID_W*i -: 4]);
            v = 3'h0;
            w = 1;
            case (id)
                parity_field: if (pos >= 0) pmask[pos] = 1'b1;
                constant_zero_field: v = 3'h0;
                constant_one_field: v = 3'h1;
                current_division_field: begin
                    v = {1'b0, div};
                    w = 2;
                end
                fmt_pkg::current_decimal_field: begin
                    v = dec;
                    w = 3;
                end
                fmt_pkg::tertiary_decimal_field: begin
                    v = tdec;
                    w = 3;
                end
                unit_flag_field: v = {2'h0, flags[4]};
                motion_flag_field: v = {2'h0, flags[3]};
                range_flag_field: v = {2'h0, flags[2]};
                polarity_flag_field: v = {2'h0, flags[1]};
                gross_net_flag_field: v = {2'h0, flags[0]};
                default: w = 0;
            endcase
            for (int k = 2; k >= 0; k--) begin
                if (k < w && pos >= 0) begin
                    b[pos] = v[k];
                    pos = pos - 1;
                end
            end
        end
        // Even parity over the data bits only
        b = b | (pmask & {8{^(b & ~pmask)}});
        return b;
    endfunction

    function automatic logic [7:0] body_char(
        input int b, input logic [31:0] digs,
        input int ndig, frac, tz, pt, fs
    );
        int ints, j;
        ints = ndig - frac;
        j = -1;
        body_char = `CHAR_ZERO;
        if (b < ints) begin
            j = ndig - 1 - b;
        end else if (b < ints + tz) begin
            j = -1;
        end else if (pt != 0 && b == ints + tz) begin
            body_char = `CHAR_POINT;
        end else if (b - ints - tz - pt < fs) begin
            // Fixed with fewer places truncates, more places pads
            j = frac - 1 - (b - ints - tz - pt);
        end
        if (j >= 0) begin
            body_char = `CHAR_ZERO + {4'h0, digs[j*4 +: 4]};
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    fmt_state_t st, next_st;
    logic push_valid, push_ready;
    logic [7:0] push_data;
    logic [23:0] mag_div;
    logic [3:0] mag_mod;
    logic [2:0] unit_dec;
    logic [4:0] fs, pt, sgn, blen, len, total, pad;
    logic [7:0] field_char;

    assign mag_div = st.mag / 24'd10;
    assign mag_mod = 4'(st.mag % 24'd10);
    assign weight_select = st.sel;
    assign weight_units = st.units;
    assign busy = (st.phase != ph_idle);
    assign tok_ready = ce && (st.phase == ph_idle);

    // ----------------------------------------
    // Weight field layout
    // ----------------------------------------
    always_comb begin
        case (st.units)
            units_primary: unit_dec = primary_decimal_field;
            units_secondary: unit_dec = secondary_decimal_field;
            units_tertiary: unit_dec = tertiary_decimal_field;
            default: unit_dec = current_decimal_field;
        endcase
    end

    assign fs = st.fixed ? {2'h0, st.fixed_digits} : {2'h0, st.frac};
    assign pt = {4'h0, (fs != 5'h0) || st.dot_always};
    assign sgn = {4'h0, st.neg && st.sign_on};
    assign blen = st.ndig - {2'h0, st.frac} + {3'h0, st.tz} + pt + fs;
    assign len = sgn + blen;
    // Width is a minimum; longer values are never cut
    assign total = ({1'b0, st.width} > len) ? {1'b0, st.width} : len;
    assign pad = total - len;

    always_comb begin
        int p;
        p = int'(st.idx);
        field_char = `CHAR_SPACE;
        if (st.zero_on) begin
            if (p < sgn) begin
                field_char = `CHAR_MINUS;
            end else if (p < sgn + pad) begin
                field_char = `CHAR_ZERO;
            end else begin
                field_char = body_char(p - sgn - pad, st.digs, st.ndig,
                    st.frac, st.tz, pt, fs);
            end
        end else if (st.right) begin
            if (p < pad) begin
                field_char = `CHAR_SPACE;
            end else if (p < pad + sgn) begin
                field_char = `CHAR_MINUS;
            end else begin
                field_char = body_char(p - pad - sgn, st.digs, st.ndig,
                    st.frac, st.tz, pt, fs);
            end
        end else begin
            if (p < sgn) begin
                field_char = `CHAR_MINUS;
            end else if (p < sgn + blen) begin
                field_char = body_char(p - sgn, st.digs, st.ndig,
                    st.frac, st.tz, pt, fs);
            end else begin
                field_char = `CHAR_SPACE;
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_st = st;
        push_valid = 1'b0;
        push_data = st.byte_val;
        case (st.phase)
            ph_idle: begin
                if (tok_valid && tok_ready) begin
                    next_st.phase = ph_single;
                    case (tok_kind)
                        kind_hex: next_st.byte_val = tok_byte;
                        kind_cr: next_st.byte_val = `CHAR_CR;
                        kind_lf: next_st.byte_val = `CHAR_LF;
                        kind_status: begin
                            next_st.byte_val = pack_status(tok_fields,
                                div_code(display_division),
                                current_decimal_field,
                                tertiary_decimal_field,
                                {unit_flag, motion_flag, range_flag,
                                 polarity_flag, gross_net_flag});
                        end
                        kind_weight: begin
                            next_st.phase = ph_load;
                            next_st.sel = tok_select;
                            next_st.units = tok_units;
                            next_st.right = tok_right;
                            next_st.sign_on = tok_sign;
                            next_st.zero_on = tok_zero;
                            next_st.width = tok_width;
                            next_st.fixed = tok_fixed;
                            next_st.fixed_digits = tok_fixed_digits;
                            next_st.dot_always = tok_dot_always;
                        end
                        default: next_st.phase = ph_idle;
                    endcase
                end
            end
            ph_load: begin
                // Lookup answers the select outputs in this cycle
                next_st.neg = weight_value[23];
                next_st.mag = weight_value[23] ? -weight_value : weight_value;
                next_st.digs = 32'h0;
                next_st.ndig = 4'h0;
                next_st.tz = 2'h0;
                next_st.frac = 3'h0;
                case (unit_dec)
                    `DEC_CODE_TWO_ZEROS: next_st.tz = 2'h2;
                    `DEC_CODE_ONE_ZERO: next_st.tz = 2'h1;
                    `DEC_CODE_INTEGER: next_st.frac = 3'h0;
                    default: next_st.frac = unit_dec - `DEC_CODE_FRAC_BASE;
                endcase
                next_st.phase = ph_convert;
            end
            ph_convert: begin
                // One digit per cycle keeps the divider small
                next_st.digs[st.ndig*4 +: 4] = mag_mod;
                next_st.ndig = st.ndig + 4'h1;
                next_st.mag = mag_div;
                if ((mag_div == 24'h0 && st.ndig >= {1'b0, st.frac})
                    || st.ndig == 4'(`MAX_DIGITS - 1)) begin
                    next_st.phase = ph_emit;
                    next_st.idx = 5'h0;
                end
            end
            ph_emit: begin
                push_valid = 1'b1;
                push_data = field_char;
                if (push_ready) begin
                    next_st.idx = st.idx + 5'h1;
                    if (st.idx == total - 5'h1) begin
                        next_st.phase = ph_idle;
                    end
                end
            end
            ph_single: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    next_st.phase = ph_idle;
                end
            end
            default: next_st.phase = ph_idle;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Output buffer
    // ----------------------------------------
    byte_fifo #(.WIDTH(`BYTE_W), .DEPTH(`FIFO_DEPTH)) out_fifo (
        .core_clk(core_clk), .reset_n(reset_n), .ce(ce),
        .in_valid(push_valid), .in_ready(push_ready),
        .in_data(push_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data)
    );
endmodule

// *** verif/formatter_properties.sv ***
// Purpose: Concurrent checks on the stream formatter ports
// Assumes: ce stays high while a checked byte is on its way
// Notes: Byte landing checks only start when the output FIFO is empty
`timescale 1ns/1ps
module formatter_properties
    import fmt_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    // Token side
    input wire logic tok_valid,
    input wire logic tok_ready,
    input wire token_kind_t tok_kind,
    input wire logic [7:0] tok_byte,
    input wire logic [31:0] tok_fields,
    input wire weight_sel_t tok_select,
    input wire units_t tok_units,
    input wire logic [1:0] weight_select,
    input wire logic [1:0] weight_units,
    // Byte side
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic take;
    logic [7:0] hex_q;
    assign take = tok_valid && tok_ready;

    // Held byte, since the token may change right after its take
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hex_q <= 8'h00;
        end else if (take) begin
            hex_q <= tok_byte;
        end
    end

    sequence taken_empty(token_kind_t k);
        take && tok_kind == k && !out_valid;
    endsequence
    sequence byte_lands(logic [7:0] b);
        ##[1:3] (out_valid && out_data == b);
    endsequence

    chk_ready_idle: assert property (tok_ready == (ce && !busy))
        else $error("token ready does not follow idle");
    chk_ce_freeze: assert property (!ce |-> !tok_ready && !out_valid)
        else $error("outputs active while ce is low");
    chk_take_busy: assert property (take |=> busy)
        else $error("not busy after a token was taken");
    chk_select_copy: assert property (
        take && tok_kind == kind_weight |=> weight_select == $past(tok_select)
        && weight_units == $past(tok_units))
        else $error("weight lookup does not follow the token");
    chk_hex_lands: assert property (
        taken_empty(kind_hex) |-> byte_lands(hex_q))
        else $error("hex byte not emitted");
    chk_cr_lands: assert property (
        taken_empty(kind_cr) |-> byte_lands(8'h0d))
        else $error("carriage return not emitted");
    chk_lf_lands: assert property (
        taken_empty(kind_lf) |-> byte_lands(8'h0a))
        else $error("line feed not emitted");
    chk_word_c: assert property (
        taken_empty(kind_status) ##0 tok_fields == 32'h01211111
        |-> byte_lands(8'ha0))
        else $error("third status byte wrong");
    chk_status_parity: assert property (
        take && tok_kind == kind_status && !out_valid
        && tok_fields[31:28] == parity_field
        |-> ##[1:3] (out_valid && ^out_data == 1'b0))
        else $error("status byte parity not even");
    chk_out_hold: assert property (
        out_valid && !out_ready ##1 ce |-> $stable(out_data) && out_valid)
        else $error("held output byte changed");
endmodule

bind weigh_stream_formatter formatter_properties chk (.core_clk, .reset_n,
    .ce, .tok_valid, .tok_ready, .tok_kind, .tok_byte, .tok_fields,
    .tok_select, .tok_units, .weight_select, .weight_units, .out_valid,
    .out_ready, .out_data, .busy);

// *** verif/stream_receiver.sv ***
// Purpose: Far-end serial receiver taking the formatted byte stream
// Assumes: One byte per edge with valid and ready high
// Notes: slow accepts one cycle in four; stop refuses everything
`timescale 1ns/1ps
module stream_receiver (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Byte stream
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [7:0] out_data,
    // Pace control
    input wire logic slow,
    input wire logic stop
);
    logic [7:0] rx_q [$];
    logic [1:0] pace = 2'h0;
    initial out_ready = 1'b0;

    // Bytes kept in arrival order
    always @(posedge core_clk) begin
        if (reset_n && out_valid && out_ready) begin
            rx_q.push_back(out_data);
        end
        #1;
        pace = pace + 2'h1;
        out_ready = reset_n && !stop && (!slow || pace == 2'h0);
    end
endmodule

// *** verif/weigh_stream_formatter_test.sv ***
// Purpose: Self-checking bench for the stream formatter
// Assumes: Receiver model drains the byte stream
// Notes: Weight lookup answers from a small table
`timescale 1ns/1ps
module weigh_stream_formatter_test
    import fmt_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
    logic tok_valid = 1'b0, tok_right = 1'b0, tok_sign = 1'b0;
    logic tok_zero = 1'b0, tok_fixed = 1'b0, tok_dot_always = 1'b0;
    token_kind_t tok_kind = kind_hex;
    weight_sel_t tok_select = sel_current;
    units_t tok_units = units_shown;
    logic [7:0] tok_byte = 8'h00;
    logic [31:0] tok_fields = 32'h0;
    logic [3:0] tok_width = 4'h0;
    logic [2:0] tok_fixed_digits = 3'h0, display_division = 3'h1;
    logic [2:0] current_decimal_field = 3'h2, tertiary_decimal_field = 3'h2;
    logic [2:0] primary_decimal_field = 3'h2;
    logic [2:0] secondary_decimal_field = 3'h2;
    logic [4:0] flags = 5'h0;
    logic [23:0] wv [4] = '{24'h0, 24'h0, 24'h0, 24'h0};
    logic [23:0] weight_value;
    logic [1:0] weight_select, weight_units;
    logic tok_ready, out_valid, out_ready, busy, slow = 1'b0, stop = 1'b0;
    logic [7:0] out_data;
    int n_fail = 0, tests_run = 0;
    localparam logic [31:0] word_a = 32'h01234bbb;
    localparam logic [31:0] word_b = 32'h0126789a;
    localparam logic [31:0] word_t = 32'h012511bb;

    always #2 core_clk = ~core_clk;
    assign weight_value = wv[weight_select] + 24'(weight_units) * 24'h3e8;

    weigh_stream_formatter dut (.core_clk, .reset_n, .ce, .tok_valid,
        .tok_ready, .tok_kind, .tok_byte, .tok_fields, .tok_select,
        .tok_right, .tok_units, .tok_sign, .tok_zero, .tok_width,
        .tok_fixed, .tok_fixed_digits, .tok_dot_always, .weight_select,
        .weight_units, .weight_value, .display_division,
        .current_decimal_field, .primary_decimal_field,
        .secondary_decimal_field, .tertiary_decimal_field,
        .unit_flag(flags[4]), .motion_flag(flags[3]),
        .range_flag(flags[2]), .polarity_flag(flags[1]),
        .gross_net_flag(flags[0]), .out_valid, .out_ready, .out_data,
        .busy);

    stream_receiver rx (.core_clk, .reset_n, .out_valid, .out_ready,
        .out_data, .slow, .stop);

    task check(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask

    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Token held until the edge that takes it, then one edge idle
    task send(input token_kind_t k);
        int n;
        n = 0;
        tok_kind = k;
        tok_valid = 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (!tok_ready && n < 500);
        if (n >= 500) check("token take", 0, 1);
        #1 tok_valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task status(input logic [31:0] f);
        tok_fields = f;
        send(kind_status);
    endtask

    task wt(input weight_sel_t s, input logic r, input units_t u,
            input logic sg, zr, input logic [3:0] w, input logic fx,
            input logic [2:0] fd, input logic dt);
        tok_select = s;
        tok_right = r;
        tok_units = u;
        tok_sign = sg;
        tok_zero = zr;
        tok_width = w;
        tok_fixed = fx;
        tok_fixed_digits = fd;
        tok_dot_always = dt;
        send(kind_weight);
    endtask

    task expect_byte(input logic [7:0] b);
        for (int n = 0; n < 400 && rx.rx_q.size() == 0; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (rx.rx_q.size() == 0) check("byte arrival", 0, 1);
        else check("out_data", rx.rx_q.pop_front(), b);
    endtask

    task expect_str(input string s);
        for (int i = 0; i < s.len(); i++) expect_byte(s[i]);
    endtask

    function automatic logic [7:0] sb(input logic [6:0] b);
        return {^b, b};
    endfunction

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        #1 reset_n = 1'b1;
        ce = 1'b0;
        @(posedge core_clk);
        #1 check("ready with ce low", tok_ready, 0);
        ce = 1'b1;
        tok_byte = 8'h02;
        send(kind_hex);
        expect_byte(8'h02);
        send(kind_cr);
        expect_byte(8'h0d);
        send(kind_lf);
        expect_byte(8'h0a);
        $display("test single bytes done");
        for (int i = 0; i < 3; i++) begin
            display_division = (i == 0) ? 3'h1 : (i == 1) ? 3'h2 : 3'h5;
            current_decimal_field = 3'(i * 3 + 1);
            status(word_a);
            expect_byte(sb({2'b01, 2'(i + 1), current_decimal_field}));
        end
        for (int i = 0; i < 5; i++) begin
            flags = 5'(i * 7);
            status(word_b);
            expect_byte(sb({2'b01, flags}));
        end
        status(32'h01211111);
        expect_byte(8'ha0);
        for (int i = 0; i < 8; i++) begin
            tertiary_decimal_field = 3'(i);
            status(word_t);
            expect_byte(sb({2'b01, 3'(i), 2'b00}));
        end
        $display("test status bytes done");
        // Slow receiver so weights back up in the FIFO
        slow = 1'b1;
        current_decimal_field = 3'h4;
        wv[0] = 24'hffff85;
        wv[1] = 24'h00007b;
        wt(sel_current, 1, units_shown, 1, 0, 4'h7, 0, 3'h0, 0);
        expect_str("  -1.23");
        wt(sel_current, 1, units_shown, 1, 1, 4'h7, 0, 3'h0, 0);
        expect_str("-001.23");
        wt(sel_current, 1, units_shown, 0, 0, 4'h7, 0, 3'h0, 0);
        expect_str("   1.23");
        wt(sel_gross, 0, units_shown, 0, 0, 4'h6, 0, 3'h0, 0);
        expect_str("1.23  ");
        wt(sel_gross, 1, units_shown, 0, 0, 4'h0, 1, 3'h1, 0);
        expect_str("1.2");
        wt(sel_gross, 1, units_shown, 0, 0, 4'h0, 1, 3'h3, 0);
        expect_str("1.230");
        current_decimal_field = 3'h2;
        wt(sel_gross, 1, units_shown, 0, 0, 4'h0, 0, 3'h0, 1);
        expect_str("123.");
        wv = '{24'h00000b, 24'h000016, 24'h000021, 24'h00002c};
        for (int s = 0; s < 4; s++) begin
            wt(weight_sel_t'(s), 1, units_shown, 0, 0, 4'h0, 0, 3'h0, 0);
            expect_str($sformatf("%0d", wv[s]));
        end
        wv[0] = 24'h000005;
        tertiary_decimal_field = 3'h0;
        for (int u = 0; u < 4; u++) begin
            wt(sel_current, 1, units_t'(u), 0, 0, 4'h0, 0, 3'h0, 0);
            expect_str(u == 3 ? "300500" : $sformatf("%0d", 5 + 1000 * u));
        end
        $display("test weights done");
        // Receiver refuses until the FIFO is full and the 17th byte waits in the formatter
        stop = 1'b1;
        for (int i = 0; i < 17; i++) begin
            tok_byte = 8'h40 + 8'(i);
            send(kind_hex);
        end
        repeat (20) @(posedge core_clk);
        #1 check("busy while full", busy, 1);
        check("ready while full", tok_ready, 0);
        stop = 1'b0;
        for (int i = 0; i < 17; i++) expect_byte(8'h40 + 8'(i));
        $display("test fifo full done");
        print_verdict;
    end

    // Whole run needs a few hundred cycles
    initial begin
        #80000;
        n_fail++;
        print_verdict;
    end
endmodule
